/* bench/cpm_board.sv */
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Board pads and pull-ups
// ********************************
module cpm_board (
  // Device pad drive
  input  wire logic [15:0] dev_gp_i,
  input  wire logic [15:0] dev_gpoe_i,
  input  wire logic [15:0] dev_hd_i,
  input  wire logic [15:0] dev_hdoe_i,
  // Board side drivers
  input  wire logic [15:0] brd_lvl_i,
  input  wire logic [15:0] brd_oe_i,
  input  wire logic [15:0] brd_hd_i,
  // Resolved pad levels
  output logic [15:0]      pad_gp_o,
  output logic [15:0]      pad_hd_o
);
  // Device wins, else board, else the pull-up lifts the pin
  assign pad_gp_o = (dev_gpoe_i & dev_gp_i) | (~dev_gpoe_i & ~brd_oe_i) |
                    (~dev_gpoe_i & brd_oe_i & brd_lvl_i);
  // Far host drives whatever the device leaves free
  assign pad_hd_o = (dev_hdoe_i & dev_hd_i) | (~dev_hdoe_i & brd_hd_i);
endmodule // cpm_board
`default_nettype wire

/* bench/cpm_pin_mux_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ********************************
// Pin mux port checker
// ********************************
module cpm_pin_mux_assertions (
  // Clock, reset, bus
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire cpm_pkg::cpm_wb_req_t wb_req_i,
  input wire cpm_pkg::cpm_wb_rsp_t wb_rsp_o,
  // Pads and straps
  input wire logic [15:0]          gp_i,
  input wire logic [15:0]          gp_o,
  input wire logic [15:0]          gp_oe_o,
  input wire logic [3:0]           external_interrupt_input_o,
  input wire logic                 clock_multiplier_select_hi_i,
  input wire logic                 clock_multiplier_select_lo_i,
  input wire logic [3:0]           pll_multiplier_o,
  // Host pads
  input wire logic [15:0]          hd_oe_o,
  input wire logic [15:0]          hpi_oe_i
);
  logic       cfg_q; // Any write since reset
  logic [1:0] md_w;  // Strap pair
  logic [3:0] mul_w; // Expected factor
  assign md_w  = {clock_multiplier_select_hi_i, clock_multiplier_select_lo_i};
  assign mul_w = (md_w == 2'b01) ? 4'h6 : (md_w == 2'b10) ? 4'hc : 4'h1;
  // Default checks only hold until software touches a register
  always_ff @(posedge clk_i)
  begin
    cfg_q <= !rst_i && (cfg_q || (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we));
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("bus request not answered next cycle");
  AST_ACK_ONE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held past one cycle");
  AST_QUARTER: assert property (disable iff (rst_i || cfg_q)
    $rose(gp_o[1]) |=> gp_o[1] ##1 !gp_o[1] [*2] ##1 gp_o[1])
    else $error("quarter clock phase wrong");
  AST_SIXTH: assert property (disable iff (rst_i || cfg_q)
    $rose(gp_o[2]) |=> gp_o[2] [*2] ##1 !gp_o[2] [*3] ##1 gp_o[2])
    else $error("sixth clock phase wrong");
  AST_DEF_OE: assert property (!cfg_q && !$past(rst_i) |-> gp_oe_o == 16'h0006)
    else $error("default pad enables wrong");
  AST_EDGE: assert property (external_interrupt_input_o[0] |->
    $past(gp_i[4]) != $past(gp_i[4], 2))
    else $error("interrupt without pad edge");
  AST_MUL: assert property ($fell(rst_i) |-> pll_multiplier_o == $past(mul_w))
    else $error("multiplier not loaded from straps");
  AST_MUL_HOLD: assert property (!$past(rst_i) |-> $stable(pll_multiplier_o))
    else $error("multiplier moved outside reset");
  AST_HOST_DEF: assert property (!cfg_q |-> hd_oe_o == hpi_oe_i)
    else $error("host pads not host owned");
  AST_PIN23: assert property (hd_oe_o[7] == hpi_oe_i[7])
    else $error("unshared host pad rerouted");
  AST_RST_DEF: assert property ($past(rst_i) |-> gp_oe_o == 16'h0 && !wb_rsp_o.ack)
    else $error("outputs not cleared by reset");
endmodule // cpm_pin_mux_assertions
bind cpm_pin_mux cpm_pin_mux_assertions u_chk (
  .clk_i                        (clk_i),
  .rst_i                        (rst_i),
  .wb_req_i                     (wb_req_i),
  .wb_rsp_o                     (wb_rsp_o),
  .gp_i                         (gp_i),
  .gp_o                         (gp_o),
  .gp_oe_o                      (gp_oe_o),
  .external_interrupt_input_o   (external_interrupt_input_o),
  .clock_multiplier_select_hi_i (clock_multiplier_select_hi_i),
  .clock_multiplier_select_lo_i (clock_multiplier_select_lo_i),
  .pll_multiplier_o             (pll_multiplier_o),
  .hd_oe_o                      (hd_oe_o),
  .hpi_oe_i                     (hpi_oe_i)
);
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ********************************
  // Stimulus, pads and counters
  // ********************************
  logic                 clk_i   = 1'b0;
  logic                 rst_i   = 1'b1;
  cpm_pkg::cpm_wb_req_t req     = '0;
  cpm_pkg::cpm_wb_rsp_t rsp;
  logic                 hi      = 1'b0;
  logic                 lo      = 1'b0;
  logic [15:0]          lvl     = 16'hffff; // Board level, pin 4 used
  logic [15:0]          boe     = 16'h0010; // Board drives pin 4 only
  logic [15:0]          hpi_oe  = 16'h00ff;
  logic [15:0]          emac_oe = 16'hff00;
  logic [15:0]          hpi_dat = 16'h5aa5;
  logic [15:0]          gp_i, gp_o, gp_oe, hd_i, hd_o, hd_oe, hpi_o, emac_o;
  logic [3:0]           irq, mul;
  logic [31:0]          rd;
  int                   n_fail = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  cpm_pin_mux u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .gp_i(gp_i), .gp_o(gp_o), .gp_oe_o(gp_oe), .external_interrupt_input_o(irq),
    .clock_multiplier_select_hi_i(hi), .clock_multiplier_select_lo_i(lo),
    .pll_multiplier_o(mul), .hd_i(hd_i), .hd_o(hd_o), .hd_oe_o(hd_oe),
    .hpi_dat_i(hpi_dat), .hpi_oe_i(hpi_oe), .hpi_dat_o(hpi_o),
    .emac_dat_i(~hpi_dat), .emac_oe_i(emac_oe), .emac_dat_o(emac_o));
  cpm_board u_brd (.dev_gp_i(gp_o), .dev_gpoe_i(gp_oe), .dev_hd_i(hd_o),
    .dev_hdoe_i(hd_oe), .brd_lvl_i(lvl), .brd_oe_i(boe), .brd_hd_i(16'hc3c3),
    .pad_gp_o(gp_i), .pad_hd_o(hd_i));
  task automatic final_report;
  begin
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // One classic cycle, held until ack is sampled, then two idle cycles:
  // a write lands on the ack edge and the pad flops follow one edge later
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
  int k;
  begin
    k = 0;
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do @(posedge clk_i); while (rsp.ack !== 1'b1 && ++k < 20);
    if (rsp.ack !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
    else
    begin
      rd = rsp.dat;
      req <= '0;
      repeat (2) @(posedge clk_i);
    end
  end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
  begin
    wb(1'b0, a, 32'h0);
    check("read data", rd, exp);
  end
  endtask
  // Rises and high samples over 24 cycles, phase free
  task automatic clk_chk(input int b, input logic [31:0] exp);
  logic [31:0] r, h;
  logic        p;
  begin
    r = 0;
    h = 0;
    p = gp_o[b];
    repeat (24)
    begin
      @(posedge clk_i);
      r = r + (gp_o[b] & ~p);
      h = h + gp_o[b];
      p = gp_o[b];
    end
    check("clock rises", r, exp);
    check("clock high", h, 32'hc);
  end
  endtask
  // Move pin 4 and count interrupt pulses
  task automatic pin4(input logic v, input logic [31:0] exp);
  logic [31:0] c;
  begin
    c = 0;
    lvl[4] <= v;
    repeat (4)
    begin
      @(posedge clk_i);
      c = c + irq[0];
    end
    check("irq pulses", c, exp);
  end
  endtask
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      {hi, lo} <= m[1:0];
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("multiplier", mul, m == 1 ? 6 : m == 2 ? 12 : 1);
    end
    $display("test straps done");
    clk_chk(1, 32'h6);
    clk_chk(2, 32'h4);
    check("pad enables", gp_oe, 16'h0006);
    check("host oe", hd_oe, hpi_oe);
    check("host rx", hpi_o, 16'hc3a5);
    check("eth rx", emac_o, 16'h0);
    wb(1'b1, 8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    rdc(cpm_pkg::CPM_OFS_GPEN, 32'hf0);
    rdc(cpm_pkg::CPM_OFS_GPDIR, 32'h0);
    $display("test defaults done");
    wb(1'b1, cpm_pkg::CPM_OFS_GPEN, 32'hf2);
    wb(1'b1, cpm_pkg::CPM_OFS_GPDIR, 32'h2);
    check("pin1 out low", {gp_oe[1], gp_o[1]}, 2'b10);
    wb(1'b1, cpm_pkg::CPM_OFS_GPOUT, 32'h2);
    check("pin1 out high", {gp_oe[1], gp_o[1]}, 2'b11);
    clk_chk(2, 32'h4);
    $display("test gpio done");
    wb(1'b1, cpm_pkg::CPM_OFS_INTEN, 32'h1);
    pin4(1'b0, 32'h0);
    pin4(1'b1, 32'h1);
    wb(1'b1, cpm_pkg::CPM_OFS_POL, 32'h1);
    pin4(1'b0, 32'h1);
    pin4(1'b1, 32'h0);
    wb(1'b1, cpm_pkg::CPM_OFS_INTEN, 32'h0);
    pin4(1'b0, 32'h0);
    $display("test interrupt done");
    wb(1'b1, cpm_pkg::CPM_OFS_HPMUX, 32'h1);
    check("eth oe", hd_oe, 16'hff80);
    check("eth rx", emac_o, 16'ha543);
    check("host rx 23", hpi_o, 16'h0080);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("host oe", hd_oe, hpi_oe);
    rdc(cpm_pkg::CPM_OFS_GPEN, 32'hf0);
    check("pad enables", gp_oe, 16'h0006);
    $display("test reset done");
    final_report();
  end
endmodule // testbench
`default_nettype wire

/* logic/cpm_pin_mux.sv */
// Contract
// - Pin one drives quarter-rate clock by default
// - Pin two drives sixth-rate clock by default
// - Clock pins become GPIO only when enabled
// - Mode pins choose multiplier x1, x6, x12
// - Pins seven to four reset as inputs
// - Upper host data shared except pin 23, host by default
// - Interrupt pins edge detect, per-pin polarity
`timescale 1ns/1ns
`default_nettype none
module cpm_pin_mux (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register bus
  input  wire cpm_pkg::cpm_wb_req_t   wb_req_i,
  output cpm_pkg::cpm_wb_rsp_t        wb_rsp_o,
  // General-purpose pad bank
  input  wire logic [15:0]            gp_i,
  output logic [15:0]                 gp_o,
  output logic [15:0]                 gp_oe_o,
  // Interrupt events to the CPU
  output logic [3:0]                  external_interrupt_input_o,
  // Multiplier straps and result
  input  wire logic                   clock_multiplier_select_hi_i,
  input  wire logic                   clock_multiplier_select_lo_i,
  output logic [3:0]                  pll_multiplier_o,
  // Upper host data pads
  input  wire logic [15:0]            hd_i,
  output logic [15:0]                 hd_o,
  output logic [15:0]                 hd_oe_o,
  // Host port side of shared pads
  input  wire logic [15:0]            hpi_dat_i,
  input  wire logic [15:0]            hpi_oe_i,
  output logic [15:0]                 hpi_dat_o,
  // Ethernet side of shared pads
  input  wire logic [15:0]            emac_dat_i,
  input  wire logic [15:0]            emac_oe_i,
  output logic [15:0]                 emac_dat_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] gpen_q;   // Pin enable
  logic [15:0] gpdir_q;  // Pin direction
  logic [15:0] gpout_q;  // Output levels
  logic [3:0]  inten_q;  // Interrupt enables
  logic [3:0]  pol_q;    // 0 rising, 1 falling
  logic        hpmux_q;  // 1 = ethernet owns pads
  logic        ack_q;    // Bus answer
  logic [31:0] rdat_q;   // Read data
  logic [3:0]  mul_q;    // Latched multiplier
  logic [3:0]  gsync_q;  // Previous interrupt pad levels
  logic [3:0]  irq_q;    // Interrupt pulses
  // Reset values come from the shared package where they matter

  // ****************************************
  // Bus decode
  // ****************************************
  // New request: strobe up and no answer pending
  wire         req    = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  // Writes land on the edge at which the master sees ack
  wire         wr     = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_q;
  // Address as offered; only the low byte is decoded
  wire [7:0]   adr    = wb_req_i.adr;
  wire [31:0]  wmask  = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                         {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire [31:0]  wdat   = wb_req_i.dat;
  // Write strobes; read-only offsets get none, so writes there drop
  wire         wr_en  = wr & (adr == cpm_pkg::CPM_OFS_GPEN);
  wire         wr_dir = wr & (adr == cpm_pkg::CPM_OFS_GPDIR);
  wire         wr_out = wr & (adr == cpm_pkg::CPM_OFS_GPOUT);
  wire         wr_ie  = wr & (adr == cpm_pkg::CPM_OFS_INTEN);
  wire         wr_pol = wr & (adr == cpm_pkg::CPM_OFS_POL);
  wire         wr_mux = wr & (adr == cpm_pkg::CPM_OFS_HPMUX);

  // Byte-lane merge of the low half word
  wire [15:0]  m16    = wmask[15:0];
  wire [15:0]  en_d   = (gpen_q & ~m16) | (wdat[15:0] & m16);
  wire [15:0]  dir_d  = (gpdir_q & ~m16) | (wdat[15:0] & m16);
  wire [15:0]  out_d  = (gpout_q & ~m16) | (wdat[15:0] & m16);

  // Read mux; unmapped offsets read zero
  wire [31:0]  rmux =
    (adr == cpm_pkg::CPM_OFS_GPEN)   ? {16'h0000, gpen_q}  :
    (adr == cpm_pkg::CPM_OFS_GPDIR)  ? {16'h0000, gpdir_q} :
    (adr == cpm_pkg::CPM_OFS_GPOUT)  ? {16'h0000, gpout_q} :
    (adr == cpm_pkg::CPM_OFS_GPIN)   ? {16'h0000, gp_i}    :
    (adr == cpm_pkg::CPM_OFS_INTEN)  ? {28'h0000000, inten_q} :
    (adr == cpm_pkg::CPM_OFS_POL)    ? {28'h0000000, pol_q}   :
    (adr == cpm_pkg::CPM_OFS_HPMUX)  ? {31'h00000000, hpmux_q} :
    (adr == cpm_pkg::CPM_OFS_STATUS) ? {28'h0000000, mul_q}   :
    32'h00000000;

  // ****************************************
  // Bus answer
  // ****************************************
  // One wait state, ack for one cycle
  // Read data is caught with the request and stands through ack;
  // the ~ack_q term keeps a held strobe from starting a second cycle
  // Unmapped offsets still answer, so a stray access never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= req ? rmux : rdat_q;
    end
  end

  // Answer carrier built in one piece, both fields from flops
  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};

  // ****************************************
  // Configuration registers
  // ****************************************
  // Reset puts every pin back to its default role
  // Narrow registers honour byte lane 0 only; wider lanes are ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gpen_q  <= cpm_pkg::CPM_GPEN_RST;
      gpdir_q <= cpm_pkg::CPM_GPDIR_RST;
      gpout_q <= 16'h0000;
      inten_q <= 4'h0;
      pol_q   <= cpm_pkg::CPM_POL_RST;
      hpmux_q <= 1'b0;
    end
    else
    begin
      if (wr_en)
        gpen_q <= en_d;
      if (wr_dir)
        gpdir_q <= dir_d;
      if (wr_out)
        gpout_q <= out_d;
      if (wr_ie & wb_req_i.sel[0])
        inten_q <= wdat[3:0];
      if (wr_pol & wb_req_i.sel[0])
        pol_q <= wdat[3:0];
      if (wr_mux & wb_req_i.sel[0])
        hpmux_q <= wdat[0];
    end
  end

  // ****************************************
  // Clock dividers
  // ****************************************
  // Counters toggle the pin flops; square waves stay glitch free
  // A half period of N cycles counts 0 to N-1, then the pin flop flips
  // Both run free from reset; the pads see them only while unclaimed
  logic [1:0] qcnt_q;
  logic [1:0] scnt_q;
  logic       qclk_q;
  logic       sclk_q;
  wire        q_wrap = (qcnt_q == cpm_pkg::CPM_Q_HALF - 2'h1);
  wire        s_wrap = (scnt_q == cpm_pkg::CPM_S_HALF - 2'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      qcnt_q <= 2'h0;
      scnt_q <= 2'h0;
      qclk_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      qcnt_q <= q_wrap ? 2'h0 : qcnt_q + 2'h1;
      scnt_q <= s_wrap ? 2'h0 : scnt_q + 2'h1;
      qclk_q <= q_wrap ? ~qclk_q : qclk_q;
      sclk_q <= s_wrap ? ~sclk_q : sclk_q;
    end
  end

  // ****************************************
  // General-purpose pad drive
  // ****************************************
  // Clock function until the enable bit is set
  // Enabled pins drive only with direction set; others float high
  wire [15:0] gp_func_oe = gpen_q & gpdir_q;
  logic [15:0] gpo_d;
  logic [15:0] gpoe_d;

  always_comb
  begin
    // Clock pins override the register image bit by bit
    gpo_d  = gpout_q;
    gpoe_d = gp_func_oe;
    if (!gpen_q[cpm_pkg::CPM_Q_PIN])
    begin
      gpo_d[cpm_pkg::CPM_Q_PIN]  = qclk_q;
      gpoe_d[cpm_pkg::CPM_Q_PIN] = 1'b1;
    end
    if (!gpen_q[cpm_pkg::CPM_S_PIN])
    begin
      gpo_d[cpm_pkg::CPM_S_PIN]  = sclk_q;
      gpoe_d[cpm_pkg::CPM_S_PIN] = 1'b1;
    end
  end

  // Pad outputs from flops; one cycle behind the dividers
  // Reset drops every drive, so nothing fights the board meanwhile
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gp_o    <= 16'h0000;
      gp_oe_o <= 16'h0000;
    end
    else
    begin
      gp_o    <= gpo_d;
      gp_oe_o <= gpoe_d;
    end
  end

  // ****************************************
  // External interrupt edges
  // ****************************************
  // Pads are synchronous; an XOR with polarity picks the edge
  // Changing polarity flips both samples, so it makes no edge
  // Enable masks the edge, not the sampling, so history stays fresh
  wire [3:0] ipin = gp_i[cpm_pkg::CPM_INT_LSB +: cpm_pkg::CPM_INT_W];
  wire [3:0] lvl  = ipin ^ pol_q;
  wire [3:0] plvl = gsync_q ^ pol_q;
  wire [3:0] rise = lvl & ~plvl & inten_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gsync_q <= 4'hf; // Pull-up idle level; no false edge after reset
      irq_q   <= 4'h0;
    end
    else
    begin
      gsync_q <= ipin;
      irq_q   <= rise;
    end
  end

  assign external_interrupt_input_o = irq_q;

  // ****************************************
  // Multiplier strap capture
  // ****************************************
  // Caught while reset is held; changes later are ignored
  // The factor only reports the straps; the loop itself lives outside
  wire [1:0] mode = {clock_multiplier_select_hi_i, clock_multiplier_select_lo_i};
  logic [3:0] mul_d;

  always_comb
  begin
    case (mode)
      cpm_pkg::CPM_MODE_BYPASS: mul_d = cpm_pkg::CPM_MUL_X1;
      cpm_pkg::CPM_MODE_X6:     mul_d = cpm_pkg::CPM_MUL_X6;
      cpm_pkg::CPM_MODE_X12:    mul_d = cpm_pkg::CPM_MUL_X12;
      default:                  mul_d = cpm_pkg::CPM_MUL_X1; // Reserved: bypass
    endcase
  end

  // Load on every reset edge; a running clock must not re-multiply
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mul_q <= mul_d;
  end

  assign pll_multiplier_o = mul_q;

  // ****************************************
  // Shared host data pads
  // ****************************************
  // Pin 23 stays with the host port whatever the select
  // Unowned side reads zero, so no peripheral sees foreign data
  logic [15:0] eth_own;

  always_comb
  begin
    eth_own = {16{hpmux_q}};
    eth_own[cpm_pkg::CPM_HD_KEEP] = 1'b0;
  end

  // Output side: owner's drive and enable; input side: pad to owner
  assign hd_o       = (emac_dat_i & eth_own) | (hpi_dat_i & ~eth_own);
  assign hd_oe_o    = (emac_oe_i & eth_own) | (hpi_oe_i & ~eth_own);
  assign hpi_dat_o  = hd_i & ~eth_own;
  assign emac_dat_o = hd_i & eth_own;

endmodule // cpm_pin_mux
`default_nettype wire

/* logic/cpm_pkg.sv */
`default_nettype none
// ****************************************
// Shared constants and types
// ****************************************
package cpm_pkg;

  // Register byte offsets
  localparam logic [7:0] CPM_OFS_GPEN   = 8'h00; // Pin enable
  localparam logic [7:0] CPM_OFS_GPDIR  = 8'h04; // Direction, 1 = out
  localparam logic [7:0] CPM_OFS_GPOUT  = 8'h08; // Output levels
  localparam logic [7:0] CPM_OFS_GPIN   = 8'h0c; // Pad levels, read only
  localparam logic [7:0] CPM_OFS_INTEN  = 8'h10; // Interrupt enables
  localparam logic [7:0] CPM_OFS_POL    = 8'h14; // Edge polarity
  localparam logic [7:0] CPM_OFS_HPMUX  = 8'h18; // Host/ethernet select
  localparam logic [7:0] CPM_OFS_STATUS = 8'h1c; // Multiplier, read only

  // Widths and field positions
  localparam int CPM_GP_W    = 16; // General-purpose bank
  localparam int CPM_INT_W   = 4;  // Interrupt-capable pins
  localparam int CPM_INT_LSB = 4;  // First interrupt pin
  localparam int CPM_Q_PIN   = 1;  // Quarter-rate clock pin
  localparam int CPM_S_PIN   = 2;  // Sixth-rate clock pin
  localparam int CPM_HD_W    = 16; // Upper host data pins, all but pin 23 shared
  localparam int CPM_HD_KEEP = 7;  // Pin 23, never shared

  // Reset values
  localparam logic [15:0] CPM_GPEN_RST  = 16'h00f0;
  localparam logic [15:0] CPM_GPDIR_RST = 16'h0000;
  localparam logic [3:0]  CPM_POL_RST   = 4'h0;

  // Divider half periods in CPU cycles
  localparam logic [1:0] CPM_Q_HALF = 2'h2;
  localparam logic [1:0] CPM_S_HALF = 2'h3;

  // Multiplier factors
  localparam logic [3:0] CPM_MUL_X1  = 4'h1;
  localparam logic [3:0] CPM_MUL_X6  = 4'h6;
  localparam logic [3:0] CPM_MUL_X12 = 4'hc;

  // Strap encodings {hi, lo}
  typedef enum logic [1:0] {
    CPM_MODE_BYPASS = 2'b00,
    CPM_MODE_X6     = 2'b01,
    CPM_MODE_X12    = 2'b10,
    CPM_MODE_RSVD   = 2'b11
  } cpm_mode_t;

  // Wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cpm_wb_req_t;

  // Wishbone answer carrier
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cpm_wb_rsp_t;

endpackage
`default_nettype wire
